// ==== hdl/color_adjust_pkg.sv ====
// Constants, command codes and field layout for the colour adjust command registers.
package color_adjust_pkg;

  // Full 16-bit command addresses used on the wide command interfaces.
  localparam logic [15:0] write_enhance2_addr = 16'h5c00;
  localparam logic [15:0] read_enhance2_addr = 16'h5d00;
  localparam logic [15:0] write_temp_shift_addr = 16'h6200;
  localparam logic [15:0] read_temp_shift_addr = 16'h6300;
  localparam logic [15:0] write_reading_look_addr = 16'h6400;

  // Reset values after power on, software reset and hardware reset.
  localparam logic [7:0] enhance2_reset = 8'h24;
  localparam logic [7:0] temp_shift_reset = 8'h00;
  localparam logic [7:0] reading_look_reset = 8'h00;

  // Field positions inside the parameter bytes.
  localparam int sunlight_enable_bit = 7;
  localparam int sunlight_level_hi = 6;
  localparam int sunlight_level_lo = 5;
  localparam int edge_enable_bit = 4;
  localparam int temp_enable_bit = 7;
  localparam int look_enable_bit = 7;
  localparam int look_level_hi = 6;

  // Decoded command kinds.
  typedef enum logic [2:0] {
    cmd_none = 3'h0,
    cmd_write_enhance2 = 3'h1,
    cmd_read_enhance2 = 3'h2,
    cmd_write_temp_shift = 3'h3,
    cmd_read_temp_shift = 3'h4,
    cmd_write_reading_look = 3'h5
  } cmd_kind_t;

  // Answer sequencer states, one-hot.
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_answer = 2'b10
  } seq_state_t;

  // Maps a command address to its kind; short form carries only the high byte.
  function automatic cmd_kind_t decode_cmd(input logic [15:0] addr, input logic short_form);
    logic [15:0] full;
    full = short_form ? {addr[7:0], 8'h00} : addr;
    case (full)
      write_enhance2_addr: decode_cmd = cmd_write_enhance2;
      read_enhance2_addr: decode_cmd = cmd_read_enhance2;
      write_temp_shift_addr: decode_cmd = cmd_write_temp_shift;
      read_temp_shift_addr: decode_cmd = cmd_read_temp_shift;
      write_reading_look_addr: decode_cmd = cmd_write_reading_look;
      default: decode_cmd = cmd_none;
    endcase
  endfunction : decode_cmd

endpackage : color_adjust_pkg

// ==== hdl/byte_store.sv ====
// One 8-bit setting register with a fixed default and a synchronous clear.
`timescale 1ns/1ns
`default_nettype none
module byte_store #(
  parameter logic [7:0] reset_value = 8'h00
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clear,
  input wire logic write_enable,
  input wire logic [7:0] write_data,
  output logic [7:0] stored
);

  logic [7:0] value_q;
  logic [7:0] value_d;

  // Clear returns the default; every bit is kept as written, even unused ones.
  always_comb begin
    value_d = value_q;
    if (clear) begin
      value_d = reset_value;
    end else if (write_enable) begin
      value_d = write_data;
    end
  end

  // Asynchronous reset loads the constant default.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      value_q <= reset_value;
    end else begin
      value_q <= value_d;
    end
  end

  assign stored = value_q;

endmodule : byte_store
`default_nettype wire

// ==== hdl/color_adjust_command_regs.sv ====
// Command register bank for the colour enhancement settings of the display driver.
`timescale 1ns/1ns
`default_nettype none
module color_adjust_command_regs (
  input wire logic clock,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic partial_mode,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_short,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_param,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic cmd_refused,
  output logic sunlight_boost_enable,
  output logic [1:0] sunlight_boost_level,
  output logic edge_sharpen_enable,
  output logic temp_shift_enable,
  output logic [7:0] temp_shift_setting,
  output logic reading_look_enable,
  output logic [6:0] reading_look_level
);

  // Stored parameter bytes.
  logic [7:0] enhance2_byte;
  logic [7:0] temp_shift_byte;
  logic [7:0] reading_look_byte;

  // Decoded request and its acceptance.
  color_adjust_pkg::cmd_kind_t kind;
  logic allowed;
  logic take;
  logic wr_enhance2;
  logic wr_temp_shift;
  logic wr_reading_look;
  logic rd_request;

  // Sequencer and answer registers.
  color_adjust_pkg::seq_state_t state_q;
  color_adjust_pkg::seq_state_t state_d;
  logic rd_valid_q;
  logic rd_valid_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic refused_q;
  logic refused_d;

  // Decode the address and the direction together; a write to a read address, a read
  // to a write address or an unknown address are all treated as unmapped.
  always_comb begin
    kind = color_adjust_pkg::decode_cmd(cmd_addr, cmd_short);
    allowed = !partial_mode && (state_q == color_adjust_pkg::st_idle);
    take = cmd_valid && allowed;
    wr_enhance2 = take && cmd_write && (kind == color_adjust_pkg::cmd_write_enhance2);
    wr_temp_shift = take && cmd_write && (kind == color_adjust_pkg::cmd_write_temp_shift);
    wr_reading_look = take && cmd_write && (kind == color_adjust_pkg::cmd_write_reading_look);
    rd_request = take && !cmd_write &&
                 ((kind == color_adjust_pkg::cmd_read_enhance2) ||
                  (kind == color_adjust_pkg::cmd_read_temp_shift));
  end

  // Enhancement-2 byte, written only by its own write command.
  byte_store #(
    .reset_value(color_adjust_pkg::enhance2_reset)
  ) enhance2_store (
    .clock(clock),
    .reset(reset),
    .clear(soft_reset),
    .write_enable(wr_enhance2),
    .write_data(cmd_param),
    .stored(enhance2_byte)
  );

  // Colour temperature shift byte.
  byte_store #(
    .reset_value(color_adjust_pkg::temp_shift_reset)
  ) temp_shift_store (
    .clock(clock),
    .reset(reset),
    .clear(soft_reset),
    .write_enable(wr_temp_shift),
    .write_data(cmd_param),
    .stored(temp_shift_byte)
  );

  // Reading look byte; its readback lives elsewhere, so only the fields leave here.
  byte_store #(
    .reset_value(color_adjust_pkg::reading_look_reset)
  ) reading_look_store (
    .clock(clock),
    .reset(reset),
    .clear(soft_reset),
    .write_enable(wr_reading_look),
    .write_data(cmd_param),
    .stored(reading_look_byte)
  );

  // Setting fields go straight from the stored flip-flops to the pixel path.
  assign sunlight_boost_enable = enhance2_byte[color_adjust_pkg::sunlight_enable_bit];
  assign sunlight_boost_level =
    enhance2_byte[color_adjust_pkg::sunlight_level_hi:color_adjust_pkg::sunlight_level_lo];
  assign edge_sharpen_enable = enhance2_byte[color_adjust_pkg::edge_enable_bit];
  // With the enable low the pixel path keeps the panel's native temperature.
  assign temp_shift_enable = temp_shift_byte[color_adjust_pkg::temp_enable_bit];
  assign temp_shift_setting = temp_shift_byte;
  assign reading_look_enable = reading_look_byte[color_adjust_pkg::look_enable_bit];
  assign reading_look_level = reading_look_byte[color_adjust_pkg::look_level_hi:0];

  // Answer sequencer: a read answers one cycle after it is taken, and the cycle
  // that presents the answer refuses commands so a slow host never sees two answers merge.
  always_comb begin
    state_d = state_q;
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    refused_d = cmd_valid && !allowed;
    case (state_q)
      color_adjust_pkg::st_idle: begin
        if (rd_request) begin
          rd_valid_d = 1'b1;
          state_d = color_adjust_pkg::st_answer;
          if (kind == color_adjust_pkg::cmd_read_enhance2) begin
            rd_data_d = enhance2_byte;
          end else begin
            rd_data_d = temp_shift_byte;
          end
        end else if (take && (wr_enhance2 || wr_temp_shift || wr_reading_look) == 1'b0) begin
          refused_d = 1'b1;
        end
      end
      color_adjust_pkg::st_answer: begin
        state_d = color_adjust_pkg::st_idle;
      end
      default: begin
        state_d = color_adjust_pkg::st_idle;
      end
    endcase
    if (soft_reset) begin
      state_d = color_adjust_pkg::st_idle;
      rd_valid_d = 1'b0;
      rd_data_d = 8'h00;
    end
  end

  // Registers of the sequencer; data reads zero until the first answer.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= color_adjust_pkg::st_idle;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      refused_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
      refused_q <= refused_d;
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign cmd_refused = refused_q;

endmodule : color_adjust_command_regs
`default_nettype wire

// ==== bench/color_adjust_checker_asserts.sv ====
// Assertion checker for the colour adjust command register bank.
`timescale 1ns/1ns
`default_nettype none
module color_adjust_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic partial_mode,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_short,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_param,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic cmd_refused,
  input wire logic sunlight_boost_enable,
  input wire logic [1:0] sunlight_boost_level,
  input wire logic edge_sharpen_enable,
  input wire logic temp_shift_enable,
  input wire logic [7:0] temp_shift_setting,
  input wire logic reading_look_enable,
  input wire logic [6:0] reading_look_level
);
  // The short form keeps only the low byte, so the upper bits must not steer the decode.
  wire logic [15:0] full = cmd_short ? {cmd_addr[7:0], 8'h00} : cmd_addr;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // A command is taken only outside partial mode and soft reset, and never in the busy cycle that presents an answer.
  sequence s_take;
    cmd_valid && !partial_mode && !rd_valid && !soft_reset;
  endsequence
  sequence s_wr(a);
    s_take ##0 (cmd_write && full == a);
  endsequence
  sequence s_rd(a);
    s_take ##0 (!cmd_write && full == a);
  endsequence
  property p_pulse; rd_valid |=> !rd_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("read answer too long");
  property p_ce2_rd; s_rd(16'h5d00) |=> rd_valid && rd_data[7:4] ==
    {sunlight_boost_enable, sunlight_boost_level, edge_sharpen_enable}; endproperty
  a_ce2_rd: assert property (p_ce2_rd) else $error("enhance2 read wrong");
  property p_ce2_wr; s_wr(16'h5c00) |=> {sunlight_boost_enable, sunlight_boost_level,
    edge_sharpen_enable} == $past(cmd_param) >> 4; endproperty
  a_ce2_wr: assert property (p_ce2_wr) else $error("enhance2 fields wrong");
  property p_ts_wr; s_wr(16'h6200) |=> temp_shift_setting == $past(cmd_param) &&
    temp_shift_enable == $past(cmd_param) >> 7; endproperty
  a_ts_wr: assert property (p_ts_wr) else $error("shift write wrong");
  property p_ts_rd; s_rd(16'h6300) |=> rd_valid && rd_data == temp_shift_setting; endproperty
  a_ts_rd: assert property (p_ts_rd) else $error("shift read wrong");
  property p_look; s_wr(16'h6400) |=>
    {reading_look_enable, reading_look_level} == $past(cmd_param); endproperty
  a_look: assert property (p_look) else $error("reading look wrong");
  property p_partial; cmd_valid && partial_mode && !soft_reset |=>
    cmd_refused && !rd_valid && $stable(temp_shift_setting); endproperty
  a_partial: assert property (p_partial) else $error("partial mode not refused");
  property p_hold; !cmd_valid && !soft_reset |=>
    $stable(temp_shift_setting) && $stable(reading_look_level); endproperty
  a_hold: assert property (p_hold) else $error("setting changed unasked");
endmodule : color_adjust_checker
bind color_adjust_command_regs color_adjust_checker u_color_adjust_checker (.clock, .reset,
  .soft_reset, .partial_mode, .cmd_valid, .cmd_write, .cmd_short, .cmd_addr, .cmd_param,
  .rd_valid, .rd_data, .cmd_refused, .sunlight_boost_enable, .sunlight_boost_level,
  .edge_sharpen_enable, .temp_shift_enable, .temp_shift_setting, .reading_look_enable,
  .reading_look_level);
`default_nettype wire

// ==== bench/host_model.sv ====
// Host side model that issues one display command at a time.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clock,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic cmd_refused,
  output logic cmd_valid,
  output logic cmd_write,
  output logic cmd_short,
  output logic [15:0] cmd_addr,
  output logic [7:0] cmd_param
);
  initial {cmd_valid, cmd_write, cmd_short, cmd_addr, cmd_param} = '0;
  // One cycle per command; on release valid drops and address and parameter are inverted so no stale value can pass as valid.
  task automatic send(input logic w, input logic s, input logic [15:0] a,
    input logic [7:0] p, output logic v, output logic [7:0] d, output logic r);
    @(posedge clock);
    {cmd_valid, cmd_write, cmd_short, cmd_addr, cmd_param} <= {1'b1, w, s, a, p};
    @(posedge clock);
    {cmd_valid, cmd_addr, cmd_param} <= {1'b0, ~a, ~p};
    #1;
    {v, d, r} = {rd_valid, rd_data, cmd_refused};
  endtask : send
endmodule : host_model
`default_nettype wire

// ==== bench/test_color_adjust_command_regs.sv ====
// Self-checking bench for the colour adjust command register bank.
`timescale 1ns/1ns
`default_nettype none
module test_color_adjust_command_regs;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic soft_reset = 1'b0;
  logic partial_mode = 1'b0;
  logic cmd_valid, cmd_write, cmd_short, rd_valid, cmd_refused, v, r;
  logic sunlight_boost_enable, edge_sharpen_enable, temp_shift_enable, reading_look_enable;
  logic [1:0] sunlight_boost_level;
  logic [6:0] reading_look_level;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_param, rd_data, temp_shift_setting, d, ce2, ts, look;
  integer errors = 0;
  integer check_count = 0;
  integer seed = 60613;
  color_adjust_command_regs u_color_adjust_command_regs (.clock, .reset, .soft_reset,
    .partial_mode, .cmd_valid, .cmd_write, .cmd_short, .cmd_addr, .cmd_param, .rd_valid,
    .rd_data, .cmd_refused, .sunlight_boost_enable, .sunlight_boost_level,
    .edge_sharpen_enable, .temp_shift_enable, .temp_shift_setting, .reading_look_enable,
    .reading_look_level);
  host_model u_host_model (.clock, .rd_valid, .rd_data, .cmd_refused, .cmd_valid,
    .cmd_write, .cmd_short, .cmd_addr, .cmd_param);
  initial forever #4 clock = ~clock;
  // Expected view of the enhance2 flags as the outputs present them.
  function automatic logic [7:0] fields(input logic [7:0] b);
    fields = {4'h0, b[7:4]};
  endfunction : fields
  // Wide enough for a flag, a data byte and a setting compared in one go.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  // Short form is picked at random with junk upper bits, which the decoder must ignore.
  task automatic cmd(input logic w, input logic [15:0] a, input logic [7:0] p);
    logic s;
    s = 1'($random(seed));
    u_host_model.send(w, s, s ? {8'($random(seed)), a[15:8]} : a, p, v, d, r);
  endtask : cmd
  initial begin
    #100000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    cmd(0, 16'h5d00, 8'h00);
    check({v, d}, 9'h124);
    for (int i = 0; i < 16; i++) begin
      {ce2, ts, look} = (i == 0) ? 24'hff807f : 24'($random(seed));
      cmd(1, 16'h5c00, ce2);
      check({sunlight_boost_enable, sunlight_boost_level, edge_sharpen_enable}, fields(ce2));
      cmd(1, 16'h6200, ts);
      check({temp_shift_enable, temp_shift_setting[6:0]}, ts);
      check(temp_shift_setting, ts);
      cmd(1, 16'h6400, look);
      check({reading_look_enable, reading_look_level}, look);
      cmd(0, 16'h5d00, 8'h00);
      check({v, d}, {1'b1, ce2});
      cmd(0, 16'h6300, 8'h00);
      check({v, d}, {1'b1, ts});
    end
    @(posedge clock);
    partial_mode <= 1'b1;
    cmd(1, 16'h6200, ~ts);
    check({v, r, temp_shift_setting}, {2'b01, ts});
    @(posedge clock);
    partial_mode <= 1'b0;
    cmd(1, 16'h6300, ~ts);
    check({r, temp_shift_setting}, {1'b1, ts});
    cmd(0, 16'h6500, 8'h00);
    check({v, r}, 2'b01);
    @(posedge clock);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    cmd(0, 16'h5d00, 8'h00);
    check({d, temp_shift_setting}, 16'h2400);
    check({reading_look_enable, reading_look_level}, 8'h00);
    check({sunlight_boost_enable, sunlight_boost_level, edge_sharpen_enable}, fields(8'h24));
    finish_test();
  end
endmodule : test_color_adjust_command_regs
`default_nettype wire
